// *** bench/ngh_link_properties.sv ***
// Checker on the shared link between node and master ends.
// Assumes store time above 8 cycles and a millisecond of at least 4 cycles.
`timescale 1ns/1ns
`default_nettype none
module ngh_link_properties
  import ngh_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic [7:0] req_bytes [8],
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_bytes [8],
  input wire logic guard_req,
  input wire logic guard_rsp,
  input wire logic hb_tx
);
  logic wr;
  logic st;
  logic [15:0] idx;
  logic [31:0] sig;
  logic [31:0] code;
  logic prod_on_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Request and answer fields, bytes least significant first
  assign wr = req_valid && req_bytes[0] == CMD_DL_EXP4;
  assign idx = {req_bytes[2], req_bytes[1]};
  assign st = wr && idx == IDX_STORE && req_bytes[3] == SUB_ONE;
  assign sig = {req_bytes[7], req_bytes[6], req_bytes[5], req_bytes[4]};
  assign code = {rsp_bytes[7], rsp_bytes[6], rsp_bytes[5], rsp_bytes[4]};
  // Tracks a nonzero producer interval, as only then may heartbeats leave
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      prod_on_r <= 1'b0;
    else if (wr && idx == IDX_PRODUCER_HB)
      prod_on_r <= sig != 32'h0;
  end
  property p_answer_echo;
    req_valid && !st |=> rsp_valid && rsp_bytes[1] == $past(req_bytes[1]) && rsp_bytes[2] == $past(req_bytes[2]);
  endproperty
  a_answer_echo: assert property (p_answer_echo) else $error("answer missing or index not echoed");
  property p_read_only;
    wr && (idx == IDX_GUARD_COB || idx == IDX_NODE_NUMBER) |=> rsp_bytes[0] == CMD_ABORT && code == ABORT_READ_ONLY;
  endproperty
  a_read_only: assert property (p_read_only) else $error("read-only object accepted a write");
  property p_bad_sig;
    st && sig != SIG_SAVE |=> rsp_valid && rsp_bytes[0] == CMD_ABORT;
  endproperty
  a_bad_sig: assert property (p_bad_sig) else $error("store with wrong signature not aborted");
  property p_store_slow;
    st && sig == SIG_SAVE |=> (!(rsp_valid && rsp_bytes[0] == CMD_DL_ACK))[*8];
  endproperty
  a_store_slow: assert property (p_store_slow) else $error("store confirmed too early");
  property p_restore_ack;
    wr && idx == IDX_RESTORE && req_bytes[3] == SUB_ONE && sig == SIG_LOAD |=> rsp_valid && rsp_bytes[0] == CMD_DL_ACK;
  endproperty
  a_restore_ack: assert property (p_restore_ack) else $error("restore request not confirmed");
  property p_cons_top;
    wr && idx == IDX_CONSUMER_HB && req_bytes[7] != 8'h00 |=> rsp_bytes[0] == CMD_ABORT;
  endproperty
  a_cons_top: assert property (p_cons_top) else $error("consumer entry with top byte set accepted");
  property p_guard_answer;
    guard_req |-> ##[0:3] guard_rsp;
  endproperty
  a_guard_answer: assert property (p_guard_answer) else $error("guard request not answered");
  property p_hb_off;
    !prod_on_r && !$past(prod_on_r) |-> !hb_tx;
  endproperty
  a_hb_off: assert property (p_hb_off) else $error("heartbeat sent with zero interval");
  property p_hb_gap;
    hb_tx |=> (!hb_tx)[*3];
  endproperty
  a_hb_gap: assert property (p_hb_gap) else $error("heartbeats closer than one millisecond");
endmodule // ngh_link_properties
`default_nettype wire

// *** bench/ngh_link_tb.sv ***
// Bench joining node and master ends over one link, judged from the user sides.
// Assumes store time cut to 50 cycles and a millisecond to 4 cycles.
`timescale 1ns/1ns
`default_nettype none
module ngh_link_tb;
  import ngh_pkg::*;
  logic clk, rst_n, cmd_valid, cmd_write, cmd_ready, guard_req, nmt_valid, hb_valid, ans_valid, ans_abort;
  logic guard_seen, hb_seen, diag_enable, term_reg_write, nv_valid, nv_store_pulse, nv_persist_term;
  logic nv_restore_pending, use_stored_ids, life_error, hb_error, diag_allowed, storing;
  logic [15:0] cmd_index, snap_guard_interval;
  logic [7:0] cmd_sub, snap_life_factor;
  logic [31:0] cmd_data, ans_data, nv_emcy_cob;
  logic [1:0] nmt_code;
  logic [10:0] hb_ident, monitored_frame_ident;
  ngh_nmt_t nmt_state;
  int mismatches = 0;
  int samples_checked = 0;
  int lat, guard_cnt, hb_cnt, store_cnt;
  ngh_link_if i_ngh_link_if ();
  ngh_node #(.STORE_CYCLES(50), .MS_CYCLES(4)) i_ngh_node (.clk(clk), .rst_n(rst_n), .ce(1'b1),
    .link(i_ngh_link_if), .node_number(8'h0a), .diag_enable(diag_enable), .term_reg_write(term_reg_write),
    .nv_emcy_cob(nv_emcy_cob), .nv_valid(nv_valid), .nv_store_pulse(nv_store_pulse),
    .nv_persist_term(nv_persist_term), .nv_restore_pending(nv_restore_pending), .snap_emcy_cob(),
    .snap_guard_interval(snap_guard_interval), .snap_life_factor(snap_life_factor), .snap_cons_hb(),
    .snap_prod_hb(), .use_stored_ids(use_stored_ids), .life_error(life_error), .hb_error(hb_error),
    .diag_allowed(diag_allowed), .monitored_frame_ident(monitored_frame_ident), .nmt_state(nmt_state),
    .storing(storing));
  ngh_master i_ngh_master (.clk(clk), .rst_n(rst_n), .ce(1'b1), .link(i_ngh_link_if), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_index(cmd_index), .cmd_sub(cmd_sub), .cmd_data(cmd_data),
    .cmd_ready(cmd_ready), .guard_req(guard_req), .nmt_valid(nmt_valid), .nmt_code(nmt_code),
    .hb_valid(hb_valid), .hb_ident(hb_ident), .ans_valid(ans_valid), .ans_abort(ans_abort),
    .ans_data(ans_data), .guard_seen(guard_seen), .hb_seen(hb_seen));
  ngh_link_properties i_ngh_link_properties (.clk(clk), .rst_n(rst_n), .req_valid(i_ngh_link_if.req_valid),
    .req_bytes(i_ngh_link_if.req_bytes), .rsp_valid(i_ngh_link_if.rsp_valid),
    .rsp_bytes(i_ngh_link_if.rsp_bytes), .guard_req(i_ngh_link_if.guard_req),
    .guard_rsp(i_ngh_link_if.guard_rsp), .hb_tx(i_ngh_link_if.hb_tx));
  // Clock at 100 MHz
  always #5 clk = ~clk;
  // Pulse counters, so a scenario may look after the pulse has gone
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      guard_cnt <= 0;
      hb_cnt <= 0;
      store_cnt <= 0;
    end
    else
    begin
      guard_cnt <= guard_cnt + (guard_seen === 1'b1);
      hb_cnt <= hb_cnt + (hb_seen === 1'b1);
      store_cnt <= store_cnt + (nv_store_pulse === 1'b1);
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // One exchange; the wait is bounded so a lost answer cannot hang the run
  task automatic sdo(input logic w, input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] d,
    input logic ab, input logic [31:0] ex);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_index <= ix;
    cmd_sub <= sb;
    cmd_data <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    lat = 0;
    do
    begin
      @(posedge clk);
      #1;
      lat++;
    end
    while (ans_valid !== 1'b1 && lat < 80);
    check("answer", ans_valid, 1'b1);
    check("abort", ans_abort, ab);
    if (ab || !w)
      check("data", ans_data, ex);
  endtask
  task automatic pulse(input int which, input logic [10:0] id);
    @(posedge clk);
    guard_req <= which == 0;
    hb_valid <= which == 1;
    hb_ident <= id;
    nmt_valid <= which == 2;
    nmt_code <= id[1:0];
    @(posedge clk);
    guard_req <= 1'b0;
    hb_valid <= 1'b0;
    nmt_valid <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic t_defaults;
    sdo(1'b0, IDX_STORE, SUB_ZERO, 32'h0, 1'b0, {24'h0, STORE_OPT_COUNT});
    sdo(1'b0, IDX_STORE, SUB_ONE, 32'h0, 1'b0, TRIGGER_READBACK);
    sdo(1'b0, IDX_RESTORE, SUB_ZERO, 32'h0, 1'b0, {24'h0, RESTORE_OPT_COUNT});
    sdo(1'b0, IDX_CONSUMER_HB, SUB_ZERO, 32'h0, 1'b0, {24'h0, CONS_HB_COUNT});
    sdo(1'b0, IDX_LIFE_FACTOR, SUB_ZERO, 32'h0, 1'b0, 32'h0);
    sdo(1'b0, IDX_NODE_NUMBER, SUB_ZERO, 32'h0, 1'b0, 32'h0000_000a);
    sdo(1'b0, IDX_EMCY_COB, SUB_ZERO, 32'h0, 1'b0, 32'h0000_008a);
  endtask
  task automatic t_guard;
    sdo(1'b1, IDX_GUARD_COB, SUB_ZERO, 32'h0000_0123, 1'b1, ABORT_READ_ONLY);
    pulse(0, 11'h0);
    repeat (60) @(posedge clk);
    check("guard answers", guard_cnt, 1);
    check("life error off", life_error, 1'b0);
    sdo(1'b1, IDX_GUARD_INTERVAL, SUB_ZERO, 32'h2, 1'b0, 32'h0);
    sdo(1'b1, IDX_LIFE_FACTOR, SUB_ZERO, 32'h3, 1'b0, 32'h0);
    pulse(0, 11'h0);
    repeat (12) @(posedge clk);
    check("life early", life_error, 1'b0);
    repeat (24) @(posedge clk);
    check("life late", life_error, 1'b1);
  endtask
  task automatic t_store;
    pulse(2, {9'h0, NGH_OPER});
    check("oper state", nmt_state, NGH_OPER);
    sdo(1'b1, IDX_STORE, SUB_ONE, SIG_SAVE, 1'b1, ABORT_STATE);
    pulse(2, {9'h0, NGH_PREOP});
    sdo(1'b1, IDX_STORE, SUB_ONE, SIG_LOAD, 1'b1, ABORT_BAD_VALUE);
    sdo(1'b1, IDX_STORE, SUB_ONE, SIG_SAVE, 1'b0, 32'h0);
    check("store time", lat >= 50, 1'b1);
    check("ids after store", use_stored_ids, 1'b1);
    check("store pulse", store_cnt, 1);
    check("snap factor", snap_life_factor, 8'h03);
    check("snap guard", snap_guard_interval, 16'h0002);
  endtask
  task automatic t_restore;
    sdo(1'b1, IDX_RESTORE, SUB_ONE, SIG_LOAD, 1'b0, 32'h0);
    check("restore pending", nv_restore_pending, 1'b1);
    sdo(1'b0, IDX_LIFE_FACTOR, SUB_ZERO, 32'h0, 1'b0, 32'h3);
  endtask
  task automatic t_hb;
    sdo(1'b1, IDX_CONSUMER_HB, SUB_ONE, 32'h0105_0003, 1'b1, ABORT_BAD_VALUE);
    sdo(1'b1, IDX_CONSUMER_HB, SUB_ONE, 32'h0005_0003, 1'b0, 32'h0);
    check("monitored", monitored_frame_ident, 11'h705);
    repeat (40) @(posedge clk);
    check("hb missing", hb_error, 1'b1);
    pulse(1, 11'h705);
    check("hb back", hb_error, 1'b0);
    sdo(1'b1, IDX_PRODUCER_HB, SUB_ZERO, 32'h2, 1'b0, 32'h0);
    lat = hb_cnt;
    repeat (100) @(posedge clk);
    check("hb rate", (hb_cnt - lat) inside {[11:13]}, 1'b1);
    sdo(1'b1, IDX_PRODUCER_HB, SUB_ZERO, 32'h0, 1'b0, 32'h0);
    lat = hb_cnt;
    repeat (40) @(posedge clk);
    check("hb stop", hb_cnt - lat, 0);
  endtask
  task automatic t_misc;
    @(posedge clk);
    term_reg_write <= 1'b1;
    diag_enable <= 1'b0;
    #1;
    check("persist", nv_persist_term, 1'b1);
    check("diag off", diag_allowed, 1'b0);
    @(posedge clk);
    term_reg_write <= 1'b0;
    diag_enable <= 1'b1;
    #1;
    check("diag on", diag_allowed, 1'b1);
    // Mid-run reset, so the stored image is what sets the identifiers
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check("ids after reset", use_stored_ids, 1'b0);
    check("restore done", nv_restore_pending, 1'b0);
    nv_valid <= 1'b1;
    repeat (3) @(posedge clk);
    check("stored ids", use_stored_ids, 1'b1);
    sdo(1'b0, IDX_EMCY_COB, SUB_ZERO, 32'h0, 1'b0, 32'h0000_0123);
  endtask
  // Main sequence; reset held ten cycles
  initial
  begin
    {clk, rst_n, cmd_valid, cmd_write, guard_req, nmt_valid, hb_valid, term_reg_write, nv_valid} = 9'h0;
    {cmd_index, cmd_sub, cmd_data, nmt_code, hb_ident} = 69'h0;
    diag_enable = 1'b1;
    nv_emcy_cob = 32'h0000_0123;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_defaults();
    t_guard();
    t_store();
    t_restore();
    t_hb();
    t_misc();
    give_verdict();
  end
  // Hang guard, far beyond the expected run of about 450 cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    mismatches++;
    give_verdict();
  end
endmodule // ngh_link_tb
`default_nettype wire

// *** hw/ngh_master.sv ***
// Master end: turns user requests into frames and returns the answers.
// Assumes the node end shares clk and answers one request at a time.
`timescale 1ns/1ns
`default_nettype none
module ngh_master
  import ngh_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  ngh_link_if.master link,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [15:0] cmd_index,
  input wire logic [7:0] cmd_sub,
  input wire logic [31:0] cmd_data,
  output logic cmd_ready,
  input wire logic guard_req,
  input wire logic nmt_valid,
  input wire logic [1:0] nmt_code,
  input wire logic hb_valid,
  input wire logic [10:0] hb_ident,
  output logic ans_valid,
  output logic ans_abort,
  output logic [31:0] ans_data,
  output logic guard_seen,
  output logic hb_seen
);
  logic busy_r;
  logic req_valid_r;
  logic [7:0] req_bytes_r [8];

  // One outstanding request; store answers can take seconds
  assign cmd_ready = !busy_r;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      busy_r <= 1'b0;
      req_valid_r <= 1'b0;
      for (int i = 0; i < 8; i++)
        req_bytes_r[i] <= 8'h00;
    end
    else if (ce)
    begin
      req_valid_r <= 1'b0;
      if (cmd_valid && !busy_r)
      begin
        busy_r <= 1'b1;
        req_valid_r <= 1'b1;
        req_bytes_r[0] <= cmd_write ? CMD_DL_EXP4 : CMD_UL_REQ;
        req_bytes_r[1] <= cmd_index[7:0];
        req_bytes_r[2] <= cmd_index[15:8];
        req_bytes_r[3] <= cmd_sub;
        req_bytes_r[4] <= cmd_data[7:0];
        req_bytes_r[5] <= cmd_data[15:8];
        req_bytes_r[6] <= cmd_data[23:16];
        req_bytes_r[7] <= cmd_data[31:24];
      end
      else if (link.rsp_valid)
        busy_r <= 1'b0;
    end
  end
  assign link.req_valid = req_valid_r;
  assign link.req_bytes = req_bytes_r;
  assign link.guard_req = ce && guard_req;
  // Pre-operational before a store is the caller's duty
  assign link.nmt_cmd = nmt_code;
  assign link.nmt_cmd_valid = ce && nmt_valid;
  assign link.hb_rx = ce && hb_valid;
  assign link.hb_rx_ident = hb_ident;

  // Answer capture, little-endian reassembly
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ans_valid <= 1'b0;
      ans_abort <= 1'b0;
      ans_data <= 32'h0;
      guard_seen <= 1'b0;
      hb_seen <= 1'b0;
    end
    else if (ce)
    begin
      ans_valid <= link.rsp_valid && busy_r;
      guard_seen <= link.guard_rsp;
      hb_seen <= link.hb_tx;
      if (link.rsp_valid)
      begin
        ans_abort <= link.rsp_bytes[0] == CMD_ABORT;
        ans_data <= {link.rsp_bytes[7], link.rsp_bytes[6], link.rsp_bytes[5], link.rsp_bytes[4]};
      end
    end
  end
endmodule // ngh_master
`default_nettype wire

// *** hw/ngh_ms_timer.sv ***
// Millisecond watchdog / interval timer with reload on kick.
// Assumes a shared millisecond tick from its owner.
`timescale 1ns/1ns
`default_nettype none
module ngh_ms_timer #(
  parameter int W = 24
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic ms_tick,
  input wire logic [W-1:0] period,
  input wire logic kick,
  output logic expire
);
  logic [W-1:0] cnt_r;
  logic live_r;

  // Zero period disables; expire is a single pulse then reloads
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cnt_r <= '0;
    else if (ce)
    begin
      if (kick || !live_r || expire)
        cnt_r <= period;
      else if (ms_tick && cnt_r != '0)
        cnt_r <= cnt_r - W'(1);
    end
  end

  // Period leaving zero loads in full first, so enabling gives no false expiry
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      live_r <= 1'b0;
    else if (ce)
      live_r <= period != '0;
  end

  assign expire = ce && live_r && period != '0 && cnt_r == '0 && !kick;
endmodule // ngh_ms_timer
`default_nettype wire

// *** hw/ngh_node.sv ***
// Node end: object dictionary for guarding, heartbeat and parameter store.
// Assumes the master end keeps its own framing; one clock, synchronous reset.
`timescale 1ns/1ns
`default_nettype none
module ngh_node
  import ngh_pkg::*;
#(
  parameter int STORE_CYCLES = STORE_TIME_MS * CYC_PER_MS,
  parameter int MS_CYCLES = CYC_PER_MS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  ngh_link_if.node link,
  input wire logic [7:0] node_number,
  input wire logic diag_enable,
  input wire logic term_reg_write,
  input wire logic [31:0] nv_emcy_cob,
  input wire logic nv_valid,
  output logic nv_store_pulse,
  output logic nv_persist_term,
  output logic nv_restore_pending,
  output logic [31:0] snap_emcy_cob,
  output logic [15:0] snap_guard_interval,
  output logic [7:0] snap_life_factor,
  output logic [31:0] snap_cons_hb,
  output logic [15:0] snap_prod_hb,
  output logic use_stored_ids,
  output logic life_error,
  output logic hb_error,
  output logic diag_allowed,
  output logic [10:0] monitored_frame_ident,
  output ngh_nmt_t nmt_state,
  output logic storing
);
  localparam int SCW = $clog2(STORE_CYCLES + 1);
  localparam int MSW = $clog2(MS_CYCLES + 1);

  logic [15:0] guard_interval_r;
  logic [7:0] life_factor_r;
  logic [31:0] emcy_cob_r;
  logic [31:0] cons_hb_r;
  logic [15:0] prod_hb_r;
  logic [SCW-1:0] store_cnt_r;
  logic [MSW-1:0] ms_cnt_r;
  logic ms_tick;
  logic stored_r;
  logic restore_r;
  logic rsp_valid_r;
  logic [7:0] rsp_bytes_r [8];
  ngh_nmt_t nmt_r;
  logic [15:0] rq_idx;
  logic [7:0] rq_sub;
  logic [31:0] rq_data;
  logic rq_write;
  logic rq_read;
  logic [23:0] life_time;
  logic life_exp;
  logic hb_tx_exp;
  logic hb_rx_exp;
  logic hb_match;

  // Decode of the request frame, little-endian fields
  assign rq_idx = {link.req_bytes[2], link.req_bytes[1]};
  assign rq_sub = link.req_bytes[3];
  assign rq_data = {link.req_bytes[7], link.req_bytes[6], link.req_bytes[5], link.req_bytes[4]};
  assign rq_write = ce && link.req_valid && link.req_bytes[0] == CMD_DL_EXP4 && !storing;
  assign rq_read = ce && link.req_valid && link.req_bytes[0] == CMD_UL_REQ && !storing;

  // Millisecond prescaler shared by all timers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ms_cnt_r <= '0;
    else if (ce)
      ms_cnt_r <= (ms_cnt_r == MSW'(MS_CYCLES - 1)) ? '0 : ms_cnt_r + MSW'(1);
  end
  assign ms_tick = ce && ms_cnt_r == MSW'(MS_CYCLES - 1);

  // Network state from master commands
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      nmt_r <= NGH_PREOP;
    else if (ce && link.nmt_cmd_valid && !storing)
      nmt_r <= ngh_nmt_t'(link.nmt_cmd);
  end

  // Writable objects; the emergency identifier is restored from store when it holds valid data
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      guard_interval_r <= GUARD_INTERVAL_RST;
      life_factor_r <= LIFE_FACTOR_RST;
      emcy_cob_r <= {21'h0, EMCY_BASE_IDENT} + {24'h0, node_number};
      cons_hb_r <= CONS_HB_RST;
      prod_hb_r <= PROD_HB_RST;
    end
    else if (ce && nv_valid && !stored_r)
      emcy_cob_r <= nv_emcy_cob;
    else if (rq_write && rq_sub == SUB_ZERO)
    begin
      unique case (rq_idx)
        IDX_GUARD_INTERVAL: guard_interval_r <= rq_data[15:0];
        IDX_LIFE_FACTOR: life_factor_r <= rq_data[7:0];
        IDX_EMCY_COB: emcy_cob_r <= rq_data;
        IDX_PRODUCER_HB: prod_hb_r <= rq_data[15:0];
        default: ;
      endcase
    end
    else if (rq_write && rq_sub == SUB_ONE && rq_idx == IDX_CONSUMER_HB
      && rq_data[31:HB_RSVD_LSB] == 8'h00)
      cons_hb_r <= rq_data;
  end

  // Store sequencer: busy for the whole store time, only from pre-operational
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      store_cnt_r <= '0;
    else if (ce)
    begin
      if (rq_write && rq_idx == IDX_STORE && rq_sub == SUB_ONE && rq_data == SIG_SAVE
        && nmt_r == NGH_PREOP)
        store_cnt_r <= SCW'(STORE_CYCLES);
      else if (store_cnt_r != '0)
        store_cnt_r <= store_cnt_r - SCW'(1);
    end
  end
  assign storing = store_cnt_r != '0;
  assign nv_store_pulse = ce && store_cnt_r == SCW'(1);

  // Stored identifiers win once a store completes or store is valid
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      stored_r <= 1'b0;
    else if (ce && (nv_store_pulse || nv_valid))
      stored_r <= 1'b1;
  end

  // Restore request is only latched; it acts at the next reset
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      restore_r <= 1'b0;
    else if (rq_write && rq_idx == IDX_RESTORE && (rq_sub == SUB_ONE || rq_sub == SUB_FACTORY)
      && rq_data == SIG_LOAD)
      restore_r <= 1'b1;
  end

  // Answer frame; read-only and unknown objects get aborts
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rsp_valid_r <= 1'b0;
      for (int i = 0; i < 8; i++)
        rsp_bytes_r[i] <= 8'h00;
    end
    else if (ce)
    begin
      rsp_valid_r <= 1'b0;
      if (rq_write || rq_read || nv_store_pulse)
      begin
        logic [31:0] val;
        logic [7:0] cmd;
        val = 32'h0;
        cmd = rq_read ? CMD_UL_EXP4 : CMD_DL_ACK;
        rsp_valid_r <= 1'b1;
        if (nv_store_pulse)
          cmd = CMD_DL_ACK;
        else if (rq_read)
        begin
          unique case (rq_idx)
            IDX_NODE_NUMBER: val = {24'h0, node_number};
            IDX_GUARD_INTERVAL: val = {16'h0, guard_interval_r};
            IDX_LIFE_FACTOR: val = {24'h0, life_factor_r};
            IDX_GUARD_COB: val = {21'h0, monitored_frame_ident};
            IDX_STORE: val = (rq_sub == SUB_ZERO) ? {24'h0, STORE_OPT_COUNT} : TRIGGER_READBACK;
            IDX_RESTORE: val = (rq_sub == SUB_ZERO) ? {24'h0, RESTORE_OPT_COUNT} : TRIGGER_READBACK;
            IDX_EMCY_COB: val = emcy_cob_r;
            IDX_CONSUMER_HB: val = (rq_sub == SUB_ZERO) ? {24'h0, CONS_HB_COUNT} : cons_hb_r;
            IDX_PRODUCER_HB: val = {16'h0, prod_hb_r};
            default:
            begin
              cmd = CMD_ABORT;
              val = ABORT_NO_OBJECT;
            end
          endcase
        end
        else
        begin
          unique case (rq_idx)
            IDX_NODE_NUMBER, IDX_GUARD_COB:
            begin
              cmd = CMD_ABORT;
              val = ABORT_READ_ONLY;
            end
            IDX_STORE:
            begin
              cmd = (rq_data != SIG_SAVE) ? CMD_ABORT : (nmt_r != NGH_PREOP) ? CMD_ABORT : 8'h00;
              val = (rq_data != SIG_SAVE) ? ABORT_BAD_VALUE : ABORT_STATE;
            end
            IDX_RESTORE:
            begin
              cmd = (rq_data == SIG_LOAD) ? CMD_DL_ACK : CMD_ABORT;
              val = ABORT_BAD_VALUE;
            end
            IDX_GUARD_INTERVAL, IDX_LIFE_FACTOR, IDX_EMCY_COB, IDX_PRODUCER_HB: ;
            IDX_CONSUMER_HB:
            begin
              cmd = (rq_data[31:HB_RSVD_LSB] == 8'h00) ? CMD_DL_ACK : CMD_ABORT;
              val = ABORT_BAD_VALUE;
            end
            default:
            begin
              cmd = CMD_ABORT;
              val = ABORT_NO_OBJECT;
            end
          endcase
          if (cmd == CMD_DL_ACK)
            val = 32'h0;
        end
        // Store acceptance defers its reply to the end of the store
        if (cmd == 8'h00)
          rsp_valid_r <= 1'b0;
        rsp_bytes_r[0] <= cmd;
        rsp_bytes_r[1] <= nv_store_pulse ? IDX_STORE[7:0] : rq_idx[7:0];
        rsp_bytes_r[2] <= nv_store_pulse ? IDX_STORE[15:8] : rq_idx[15:8];
        rsp_bytes_r[3] <= nv_store_pulse ? SUB_ONE : rq_sub;
        rsp_bytes_r[4] <= val[7:0];
        rsp_bytes_r[5] <= val[15:8];
        rsp_bytes_r[6] <= val[23:16];
        rsp_bytes_r[7] <= val[31:24];
      end
    end
  end
  assign link.rsp_valid = rsp_valid_r;
  assign link.rsp_bytes = rsp_bytes_r;

  // Life guarding watchdog
  assign life_time = 24'(guard_interval_r) * 24'(life_factor_r);
  ngh_ms_timer #(.W(24)) u_life (.clk(clk), .rst_n(rst_n), .ce(ce && !storing), .ms_tick(ms_tick),
    .period(life_time), .kick(link.guard_req), .expire(life_exp));
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      life_error <= 1'b0;
    else if (life_exp)
      life_error <= 1'b1;
    else if (ce && link.guard_req)
      life_error <= 1'b0;
  end
  assign link.guard_rsp = ce && link.guard_req && !storing;

  // Producer heartbeat
  ngh_ms_timer #(.W(16)) u_prod (.clk(clk), .rst_n(rst_n), .ce(ce && !storing), .ms_tick(ms_tick),
    .period(prod_hb_r), .kick(1'b0), .expire(hb_tx_exp));
  assign link.hb_tx = hb_tx_exp;

  // Consumer heartbeat
  assign monitored_frame_ident = HB_BASE_IDENT + {3'h0, cons_hb_r[HB_NODE_LSB +: 8]};
  assign hb_match = ce && link.hb_rx && link.hb_rx_ident == monitored_frame_ident;
  ngh_ms_timer #(.W(16)) u_cons (.clk(clk), .rst_n(rst_n), .ce(ce && !storing), .ms_tick(ms_tick),
    .period(cons_hb_r[HB_TIME_LSB +: 16]), .kick(hb_match), .expire(hb_rx_exp));
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      hb_error <= 1'b0;
    else if (hb_rx_exp)
      hb_error <= 1'b1;
    else if (hb_match)
      hb_error <= 1'b0;
  end

  // Side outputs toward the parameter store
  assign nv_persist_term = ce && term_reg_write;
  assign nv_restore_pending = restore_r;
  assign snap_emcy_cob = emcy_cob_r;
  assign snap_guard_interval = guard_interval_r;
  assign snap_life_factor = life_factor_r;
  assign snap_cons_hb = cons_hb_r;
  assign snap_prod_hb = prod_hb_r;
  assign use_stored_ids = stored_r;
  assign diag_allowed = diag_enable && !emcy_cob_r[31];
  assign nmt_state = nmt_r;
endmodule // ngh_node
`default_nettype wire

// *** include/ngh_link_if.sv ***
// Link carrying expedited SDO frames and guard/heartbeat events.
// Assumes both ends share clk; frames are eight bytes, least significant first.
`timescale 1ns/1ns
`default_nettype none
interface ngh_link_if;
  logic req_valid;
  logic [7:0] req_bytes [8];
  logic rsp_valid;
  logic [7:0] rsp_bytes [8];
  logic guard_req;
  logic guard_rsp;
  logic [10:0] hb_rx_ident;
  logic hb_rx;
  logic hb_tx;
  logic [1:0] nmt_cmd;
  logic nmt_cmd_valid;
  modport node (input req_valid, req_bytes, guard_req, hb_rx, hb_rx_ident, nmt_cmd, nmt_cmd_valid,
    output rsp_valid, rsp_bytes, guard_rsp, hb_tx);
  modport master (output req_valid, req_bytes, guard_req, hb_rx, hb_rx_ident, nmt_cmd, nmt_cmd_valid,
    input rsp_valid, rsp_bytes, guard_rsp, hb_tx);
endinterface
`default_nettype wire

// *** include/ngh_pkg.sv ***
// Package for the node guarding, heartbeat and parameter store link.
// Assumes one 100 MHz clock shared by both ends of the link.
`default_nettype none
package ngh_pkg;
  // Object indices
  localparam logic [15:0] IDX_NODE_NUMBER = 16'h100b;
  localparam logic [15:0] IDX_GUARD_INTERVAL = 16'h100c;
  localparam logic [15:0] IDX_LIFE_FACTOR = 16'h100d;
  localparam logic [15:0] IDX_GUARD_COB = 16'h100e;
  localparam logic [15:0] IDX_STORE = 16'h1010;
  localparam logic [15:0] IDX_RESTORE = 16'h1011;
  localparam logic [15:0] IDX_EMCY_COB = 16'h1014;
  localparam logic [15:0] IDX_CONSUMER_HB = 16'h1016;
  localparam logic [15:0] IDX_PRODUCER_HB = 16'h1017;
  // Sub-indices
  localparam logic [7:0] SUB_ZERO = 8'h00;
  localparam logic [7:0] SUB_ONE = 8'h01;
  localparam logic [7:0] SUB_FACTORY = 8'h04;
  // Read-back constants and reset values
  localparam logic [7:0] STORE_OPT_COUNT = 8'h01;
  localparam logic [7:0] RESTORE_OPT_COUNT = 8'h04;
  localparam logic [7:0] CONS_HB_COUNT = 8'h02;
  localparam logic [31:0] TRIGGER_READBACK = 32'h0000_0001;
  localparam logic [7:0] LIFE_FACTOR_RST = 8'h00;
  localparam logic [15:0] GUARD_INTERVAL_RST = 16'h0000;
  localparam logic [31:0] CONS_HB_RST = 32'h0000_0000;
  localparam logic [15:0] PROD_HB_RST = 16'h0000;
  // Signatures
  localparam logic [31:0] SIG_SAVE = 32'h6576_6173;
  localparam logic [31:0] SIG_LOAD = 32'h6461_6f6c;
  // Command bytes
  localparam logic [7:0] CMD_DL_EXP4 = 8'h23;
  localparam logic [7:0] CMD_DL_ACK = 8'h60;
  localparam logic [7:0] CMD_UL_REQ = 8'h40;
  localparam logic [7:0] CMD_UL_EXP4 = 8'h43;
  localparam logic [7:0] CMD_ABORT = 8'h80;
  // Abort codes
  localparam logic [31:0] ABORT_READ_ONLY = 32'h0601_0002;
  localparam logic [31:0] ABORT_NO_OBJECT = 32'h0602_0000;
  localparam logic [31:0] ABORT_BAD_VALUE = 32'h0609_0030;
  localparam logic [31:0] ABORT_STATE = 32'h0800_0022;
  // Identifier bases and field layout
  localparam logic [10:0] HB_BASE_IDENT = 11'h700;
  localparam logic [10:0] EMCY_BASE_IDENT = 11'h080;
  localparam int HB_TIME_LSB = 0;
  localparam int HB_NODE_LSB = 16;
  localparam int HB_RSVD_LSB = 24;
  localparam int DIAG_ENABLE_BIT = 0;
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int MS_NS = 1_000_000;
  localparam int CLK_NS = 1000 / CLK_MHZ;
  localparam int CYC_PER_MS = MS_NS / CLK_NS;
  localparam int STORE_TIME_MS = 3000;
  // Link node states
  typedef enum logic [1:0] {
    NGH_PREOP = 2'b00,
    NGH_OPER = 2'b01,
    NGH_STOPPED = 2'b11
  } ngh_nmt_t;
endpackage
`default_nettype wire
